// ==== hdl/mss_consts.vh ====
// constants for the serial port master: register offsets, bit fields, resets
// assumes inclusion by bare name from the design files
`ifndef MSS_CONSTS_VH
`define MSS_CONSTS_VH
`define MSS_CLK_HZ        20000000
// register offsets on the plain register port
`define MSS_OFS_RELOAD    3'h0
`define MSS_OFS_BUF       3'h1
`define MSS_OFS_CON1      3'h2
`define MSS_OFS_CON2      3'h3
`define MSS_OFS_CON3      3'h4
`define MSS_OFS_MASK      3'h5
`define MSS_OFS_STATUS    3'h6
`define MSS_OFS_FLAGS     3'h7
// reset values
`define MSS_RST_BYTE      8'h00
// control one fields
`define MSS_C1_WCOL       7
`define MSS_C1_OVF        6
`define MSS_C1_EN         5
// control two fields
`define MSS_C2_ACKSTAT    6
`define MSS_C2_ACKDT      5
`define MSS_C2_ACKEN      4
`define MSS_C2_RCEN       3
`define MSS_C2_PEN        2
`define MSS_C2_RSEN       1
`define MSS_C2_SEN        0
// status fields
`define MSS_ST_STOP       4
`define MSS_ST_START      3
`define MSS_ST_TXACT      2
`define MSS_ST_BF         0
// flag register fields
`define MSS_FL_BCOL       0
`define MSS_FL_EVENT      1
// bit counter
`define MSS_LAST_DATA     4'h7
`define MSS_ACK_BIT       4'h8
`endif

// ==== hdl/mss_sync.v ====
// two-flop synchroniser for the two bus lines
// assumes asynchronous pin levels and one system clock
`timescale 1ns/1ns
module mss_sync (
  // system
  input  wire       clock,
  input  wire       rst_n,
  // pins in, synchronised out
  input  wire [1:0] pin_in,
  output reg  [1:0] pin_sync
);
  reg [1:0] meta_r;

  // lines idle high, so reset to high
  always @(posedge clock) begin
    if (!rst_n) begin
      meta_r   <= 2'h3;
      pin_sync <= 2'h3;
    end else begin
      meta_r   <= pin_in;
      pin_sync <= meta_r;
    end
  end
endmodule

// ==== hdl/mss_baud.v ====
// baud generator: down counter from the reload value, one tick per rollover
// assumes load and run come from logic on the same clock
`timescale 1ns/1ns
module mss_baud (
  // system
  input  wire       clock,
  input  wire       rst_n,
  // control
  input  wire [7:0] reload,
  input  wire       load,
  input  wire       run,
  // rollover
  output wire       tick
);
  reg [7:0] cnt_r;
  reg       pre_r;

  // counter steps at half the clock rate, so one rollover is 2*(reload+1) clocks
  assign tick = run & pre_r & ~load & (cnt_r == 8'h00);

  always @(posedge clock) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      pre_r <= 1'b0;
    end else if (load) begin
      cnt_r <= reload;
      pre_r <= 1'b0;
    end else if (run) begin
      pre_r <= ~pre_r;
      if (pre_r) begin
        if (cnt_r == 8'h00)
          cnt_r <= reload;
        else
          cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule

// ==== hdl/mss_master.v ====
// serial port master with bus arbitration, collision handling and baud timing
// assumes open-drain lines resolved outside; registers on a plain strobe port
`timescale 1ns/1ns
`include "mss_consts.vh"
// Summary of operation
// - a released-high data bit read low is a collision; flag and go idle
// - collision in a byte stops shifting, clears buffer full, releases both lines
// - collision in start, restart, stop or ack aborts and clears its enable bit
// - after losing, watch the bus and raise the event flag on a stop
// - a buffer write after a collision starts again from the top bit
// - either line low when a start begins aborts it with a collision
// - start: data high loads the generator; clock low meanwhile is a collision
// - data pulled low in the first start count: reload and drive data at once
// - else data low at count end, count again ignoring clock, then clock low
// - restart: release data, count, release clock; data low then is collision
// - restart count: data falling is fine, clock falling first is collision
// - both high at timeout: data low, count again, then clock low, done
// - stop: data low, release clock, count once high, then check data
// - stop: clock low after release before data is let go is a collision
// - generator reloads from the baud register and starts on a buffer write
// - generator stops when the operation ends; clock line keeps its level
// - two reloads per bus clock; bus rate is clock over 4*(reload+1)
module mss_master (
  // system
  input  wire       clock,
  input  wire       rst_n,
  // register port
  input  wire [2:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  // data line
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  // clock line
  input  wire       scl_in,
  output reg        scl_out,
  output reg        scl_oe
);
  localparam ST_IDLE = 4'h0;
  localparam ST_SA   = 4'h1;
  localparam ST_SB   = 4'h2;
  localparam ST_RA   = 4'h3;
  localparam ST_RB   = 4'h4;
  localparam ST_RC   = 4'h5;
  localparam ST_RD   = 4'h6;
  localparam ST_PA   = 4'h7;
  localparam ST_PB   = 4'h8;
  localparam ST_PC   = 4'h9;
  localparam ST_PD   = 4'ha;
  localparam ST_XL   = 4'hb;
  localparam ST_XW   = 4'hc;
  localparam ST_XH   = 4'hd;

  reg  [3:0] state_r;
  reg  [7:0] reload_r;
  reg  [7:0] shift_r;
  reg  [7:0] con1_r;
  reg  [7:0] con2_r;
  reg  [7:0] con3_r;
  reg  [7:0] mask_r;
  reg        bf_r;
  reg        stop_r;
  reg        start_r;
  reg        bcol_r;
  reg        event_r;
  reg        lost_r;
  reg        ack_mode_r;
  reg  [3:0] bit_r;
  reg        load_r;
  reg        sda_p_r;
  reg        scl_p_r;
  reg        coll;
  reg  [7:0] rd_val;
  wire [1:0] line_s;
  wire       sda_s;
  wire       scl_s;
  wire       tick;
  wire       idle;
  wire       tx_bit;
  wire       start_det;
  wire       stop_det;

  assign sda_s     = line_s[0];
  assign scl_s     = line_s[1];
  assign idle      = (state_r == ST_IDLE);
  assign tx_bit    = ack_mode_r ? con2_r[`MSS_C2_ACKDT] :
                     (bit_r == `MSS_ACK_BIT) ? 1'b1 : shift_r[7];
  assign start_det = scl_s & scl_p_r & sda_p_r & ~sda_s;
  assign stop_det  = scl_s & scl_p_r & ~sda_p_r & sda_s;

  mss_sync u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .pin_in   ({scl_in, sda_in}),
    .pin_sync (line_s)
  );

  mss_baud u_baud (
    .clock  (clock),
    .rst_n  (rst_n),
    .reload (reload_r),
    .load   (load_r),
    .run    (~idle),
    .tick   (tick)
  );

  // collision detection per phase
  always @* begin
    coll = 1'b0;
    case (state_r)
      ST_SA: coll = sda_s & ~scl_s;
      ST_RC: coll = sda_s & ~scl_s;
      ST_PC: coll = ~scl_s;
      ST_PD: coll = tick & ~sda_s;
      ST_XH: coll = ~ack_mode_r & (bit_r == `MSS_ACK_BIT) ? 1'b0 :
                    (tx_bit & ~sda_s);
      default: coll = 1'b0;
    endcase
  end

  always @* begin
    case (addr)
      `MSS_OFS_RELOAD: rd_val = reload_r;
      `MSS_OFS_BUF:    rd_val = shift_r;
      `MSS_OFS_CON1:   rd_val = con1_r;
      `MSS_OFS_CON2:   rd_val = con2_r;
      `MSS_OFS_CON3:   rd_val = con3_r;
      `MSS_OFS_MASK:   rd_val = mask_r;
      `MSS_OFS_STATUS: rd_val = {3'h0, stop_r, start_r, ~idle, 1'b0, bf_r};
      `MSS_OFS_FLAGS:  rd_val = {6'h00, event_r, bcol_r};
      default:         rd_val = 8'h00;
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      state_r    <= ST_IDLE;
      reload_r   <= `MSS_RST_BYTE;
      shift_r    <= `MSS_RST_BYTE;
      con1_r     <= `MSS_RST_BYTE;
      con2_r     <= `MSS_RST_BYTE;
      con3_r     <= `MSS_RST_BYTE;
      mask_r     <= `MSS_RST_BYTE;
      bf_r       <= 1'b0;
      stop_r     <= 1'b0;
      start_r    <= 1'b0;
      bcol_r     <= 1'b0;
      event_r    <= 1'b0;
      lost_r     <= 1'b0;
      ack_mode_r <= 1'b0;
      bit_r      <= 4'h0;
      load_r     <= 1'b0;
      sda_p_r    <= 1'b1;
      scl_p_r    <= 1'b1;
      rdata      <= 8'h00;
      sda_out    <= 1'b0;
      sda_oe     <= 1'b0;
      scl_out    <= 1'b0;
      scl_oe     <= 1'b0;
    end else begin
      load_r  <= 1'b0;
      sda_p_r <= sda_s;
      scl_p_r <= scl_s;
      rdata   <= rd ? rd_val : 8'h00;
      // software side; hardware sets below override clears in the same cycle
      if (wr) begin
        case (addr)
          `MSS_OFS_RELOAD: reload_r <= wdata;
          `MSS_OFS_CON1:   con1_r <= wdata;
          `MSS_OFS_CON3:   con3_r <= wdata;
          `MSS_OFS_MASK:   mask_r <= wdata;
          `MSS_OFS_FLAGS: begin
            bcol_r  <= bcol_r & wdata[`MSS_FL_BCOL];
            event_r <= event_r & wdata[`MSS_FL_EVENT];
          end
          `MSS_OFS_CON2: begin
            con2_r[7:5] <= {wdata[7], con2_r[6], wdata[5]};
            // sequence enables only take while idle: no queuing
            if (idle && con1_r[`MSS_C1_EN])
              con2_r[4:0] <= wdata[4:0];
          end
          `MSS_OFS_BUF: begin
            if (idle && con1_r[`MSS_C1_EN]) begin
              shift_r    <= wdata;
              bit_r      <= 4'h0;
              bf_r       <= 1'b1;
              ack_mode_r <= 1'b0;
              load_r     <= 1'b1;
              sda_oe     <= ~wdata[7];
              scl_oe     <= 1'b1;
              state_r    <= ST_XL;
            end else begin
              con1_r[`MSS_C1_WCOL] <= 1'b1;
            end
          end
          default: ;
        endcase
      end
      // bus monitor keeps running after a loss; placed after the write so a stop wins
      if (start_det) begin
        start_r <= 1'b1;
        stop_r  <= 1'b0;
      end
      if (stop_det) begin
        stop_r  <= 1'b1;
        start_r <= 1'b0;
        if (lost_r) begin
          event_r <= 1'b1;
          lost_r  <= 1'b0;
        end
      end
      if (!con1_r[`MSS_C1_EN]) begin
        state_r <= ST_IDLE;
        sda_oe  <= 1'b0;
        scl_oe  <= 1'b0;
        stop_r  <= 1'b0;
        start_r <= 1'b0;
      end else if (coll) begin
        state_r       <= ST_IDLE;
        bcol_r        <= 1'b1;
        lost_r        <= 1'b1;
        bf_r          <= 1'b0;
        sda_oe        <= 1'b0;
        scl_oe        <= 1'b0;
        con2_r[4:0]   <= 5'h00;
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (con2_r[`MSS_C2_SEN]) begin
              if (!sda_s || !scl_s) begin
                bcol_r               <= 1'b1;
                lost_r               <= 1'b1;
                con2_r[`MSS_C2_SEN]  <= 1'b0;
                sda_oe               <= 1'b0;
                scl_oe               <= 1'b0;
              end else begin
                load_r  <= 1'b1;
                state_r <= ST_SA;
              end
            end else if (con2_r[`MSS_C2_RSEN]) begin
              sda_oe  <= 1'b0;
              scl_oe  <= 1'b1;
              load_r  <= 1'b1;
              state_r <= ST_RA;
            end else if (con2_r[`MSS_C2_PEN]) begin
              sda_oe  <= 1'b1;
              scl_oe  <= 1'b1;
              load_r  <= 1'b1;
              state_r <= ST_PA;
            end else if (con2_r[`MSS_C2_ACKEN]) begin
              ack_mode_r <= 1'b1;
              sda_oe     <= ~con2_r[`MSS_C2_ACKDT];
              scl_oe     <= 1'b1;
              load_r     <= 1'b1;
              state_r    <= ST_XL;
            end
          end
          ST_SA: begin
            if (!sda_s || tick) begin
              sda_oe  <= 1'b1;
              load_r  <= 1'b1;
              state_r <= ST_SB;
            end
          end
          ST_SB: begin
            if (tick) begin
              scl_oe              <= 1'b1;
              con2_r[`MSS_C2_SEN] <= 1'b0;
              event_r             <= 1'b1;
              state_r             <= ST_IDLE;
            end
          end
          ST_RA: begin
            if (tick) begin
              scl_oe  <= 1'b0;
              state_r <= ST_RB;
            end
          end
          ST_RB: begin
            if (scl_s) begin
              if (!sda_s) begin
                bcol_r       <= 1'b1;
                lost_r       <= 1'b1;
                con2_r[4:0]  <= 5'h00;
                state_r      <= ST_IDLE;
              end else begin
                load_r  <= 1'b1;
                state_r <= ST_RC;
              end
            end
          end
          ST_RC: begin
            // another master pulling data low first is not a collision
            if (!sda_s || tick) begin
              sda_oe  <= 1'b1;
              load_r  <= 1'b1;
              state_r <= ST_RD;
            end
          end
          ST_RD: begin
            if (tick) begin
              scl_oe               <= 1'b1;
              con2_r[`MSS_C2_RSEN] <= 1'b0;
              event_r              <= 1'b1;
              state_r              <= ST_IDLE;
            end
          end
          ST_PA: begin
            if (tick && !sda_s) begin
              scl_oe  <= 1'b0;
              state_r <= ST_PB;
            end
          end
          ST_PB: begin
            if (scl_s) begin
              load_r  <= 1'b1;
              state_r <= ST_PC;
            end
          end
          ST_PC: begin
            if (tick) begin
              sda_oe  <= 1'b0;
              load_r  <= 1'b1;
              state_r <= ST_PD;
            end
          end
          ST_PD: begin
            if (tick) begin
              con2_r[`MSS_C2_PEN] <= 1'b0;
              event_r             <= 1'b1;
              state_r             <= ST_IDLE;
            end
          end
          ST_XL: begin
            if (tick) begin
              scl_oe  <= 1'b0;
              state_r <= ST_XW;
            end
          end
          ST_XW: begin
            // waits for the slowest party holding the clock low
            if (scl_s) begin
              load_r  <= 1'b1;
              state_r <= ST_XH;
            end
          end
          ST_XH: begin
            if (tick) begin
              scl_oe <= 1'b1;
              if (ack_mode_r) begin
                con2_r[`MSS_C2_ACKEN] <= 1'b0;
                ack_mode_r            <= 1'b0;
                event_r               <= 1'b1;
                state_r               <= ST_IDLE;
              end else if (bit_r == `MSS_ACK_BIT) begin
                con2_r[`MSS_C2_ACKSTAT] <= sda_s;
                event_r                 <= 1'b1;
                state_r                 <= ST_IDLE;
              end else begin
                if (bit_r == `MSS_LAST_DATA)
                  bf_r <= 1'b0;
                shift_r <= {shift_r[6:0], 1'b0};
                bit_r   <= bit_r + 4'h1;
                sda_oe  <= (bit_r == `MSS_LAST_DATA) ? 1'b0 : ~shift_r[6];
                state_r <= ST_XL;
              end
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// ==== tb/mss_checker.sv ====
// checker: line timing and flag relations at the master's ports
// assumes the design header is on the include path
`timescale 1ns/1ns
`include "mss_consts.vh"
module mss_checker (
  // system
  input wire       clock,
  input wire       rst_n,
  // register port
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata,
  // bus lines
  input wire       sda_in,
  input wire       sda_out,
  input wire       sda_oe,
  input wire       scl_in,
  input wire       scl_out,
  input wire       scl_oe
);
  localparam int START_MAX = 600;
  reg       en_r;
  reg       seen_r;
  reg       rdf_r;
  reg       rds_r;
  reg [7:0] reload_r;
  reg [9:0] hi_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  always @(posedge clock) begin
    if (!rst_n) begin
      en_r     <= 1'b0;
      seen_r   <= 1'b0;
      rdf_r    <= 1'b0;
      rds_r    <= 1'b0;
      reload_r <= 8'h00;
      hi_r     <= 10'h000;
    end else begin
      rdf_r <= rd && addr == `MSS_OFS_FLAGS;
      rds_r <= rd && addr == `MSS_OFS_STATUS;
      if (wr && addr == `MSS_OFS_CON1) en_r <= wdata[`MSS_C1_EN];
      if (wr && addr == `MSS_OFS_RELOAD) reload_r <= wdata;
      if (wr && addr == `MSS_OFS_FLAGS && !wdata[`MSS_FL_BCOL]) seen_r <= 1'b0;
      else if (rdf_r && rdata[`MSS_FL_BCOL]) seen_r <= 1'b1;
      // time the line has stood high on its own, saturating
      if (scl_oe || !scl_in) hi_r <= 10'h000;
      else if (hi_r != 10'h3ff) hi_r <= hi_r + 10'h001;
    end
  end
  a_drive_zero: assert property (!sda_out && !scl_out)
    else $error("line drive value not zero");
  a_start_finish: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:START_MAX] scl_oe)
    else $error("start left clock line released");
  a_start_abort: assert property ((!scl_in && !scl_oe && !sda_oe)[*3] ##0
    (wr && addr == `MSS_OFS_CON2 && wdata[`MSS_C2_SEN]) |=> (!sda_oe)[*8])
    else $error("start driven on a busy clock line");
  a_lost_release: assert property (rdf_r && rdata[`MSS_FL_BCOL] |-> !sda_oe && !scl_oe)
    else $error("lines held after collision");
  a_flag_sticky: assert property (rdf_r && seen_r |-> rdata[`MSS_FL_BCOL])
    else $error("collision flag lost without clear");
  a_msb_first: assert property (wr && addr == `MSS_OFS_BUF && en_r |=>
    sda_oe == ~$past(wdata[7]) && scl_oe)
    else $error("byte did not begin at top bit");
  a_high_phase: assert property ($rose(scl_oe) |-> hi_r >= {1'b0, reload_r, 1'b0})
    else $error("clock high phase too short");
  a_low_phase: assert property ($rose(scl_oe) |=> scl_oe[*6])
    else $error("clock low phase too short");
  a_status_excl: assert property (rds_r |-> !(rdata[`MSS_ST_STOP] && rdata[`MSS_ST_START]))
    else $error("start and stop seen together");
  c_start: cover property ($rose(sda_oe) && !scl_oe);
  c_lost: cover property (rdf_r && rdata[`MSS_FL_BCOL]);
  c_stop: cover property (rds_r && rdata[`MSS_ST_STOP]);
endmodule
bind mss_master mss_checker i_chk (.clock(clock), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe));

// ==== tb/mss_bus_model.sv ====
// far side of the bus: pull-ups, other masters and a stretching slave
// assumes open-drain enables, high meaning the line is pulled low
`timescale 1ns/1ns
module mss_bus_model (
  // system
  input  wire       clock,
  // device enables
  input  wire       dut_sda_oe,
  input  wire       dut_scl_oe,
  // other parties
  input  wire       pull_sda,
  input  wire       pull_scl,
  input  wire [3:0] stretch,
  // resolved lines
  output wire       sda,
  output wire       scl
);
  reg [3:0] hold_r = 4'h0;
  // a slow slave keeps the clock low a while after the master lets go;
  // armed while the master pulls low so no high glitch shows at release
  always @(posedge clock) begin
    if (dut_scl_oe) hold_r <= stretch;
    else if (hold_r != 4'h0) hold_r <= hold_r - 4'h1;
  end
  // released lines go high through the pull-ups
  assign sda = !(dut_sda_oe || pull_sda);
  assign scl = !(dut_scl_oe || pull_scl || hold_r != 4'h0);
endmodule

// ==== tb/tb_mss_master.sv ====
// testbench for the serial port master: registers, start, bytes, collisions
// assumes the design header is on the include path
`timescale 1ns/1ns
`include "mss_consts.vh"
module tb_mss_master;
  reg        clock    = 1'b0;
  reg        rst_n    = 1'b0;
  reg  [2:0] addr     = 3'h0;
  reg  [7:0] wdata    = 8'h00;
  reg        wr       = 1'b0;
  reg        rd       = 1'b0;
  reg        pull_sda = 1'b0;
  reg        pull_scl = 1'b0;
  reg  [3:0] stretch  = 4'h0;
  reg  [8:0] sh       = 9'h000;
  reg  [7:0] d;
  reg [18:0] rows [0:3];
  wire [7:0] rdata;
  wire       sda, scl, sda_out, sda_oe, scl_out, scl_oe;
  integer    err_count = 0;
  integer    total_checks = 0;
  integer    cyc = 0;
  integer    i;
  mss_master i_dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe));
  mss_bus_model i_bus (.clock(clock), .dut_sda_oe(sda_oe), .dut_scl_oe(scl_oe),
    .pull_sda(pull_sda), .pull_scl(pull_scl), .stretch(stretch), .sda(sda), .scl(scl));
  always #25 clock = ~clock;
  // data line as seen at each rising clock edge on the wire
  always @(posedge scl) sh = {sh[7:0], sda};
  task stop_test;
    begin
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      stop_test;
    end
  end
  task check(input [63:0] name, input [7:0] seen, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("BAD %0s exp %h seen %h", name, exp, seen);
      end
    end
  endtask
  task wr_reg(input [2:0] a, input [7:0] v);
    begin
      @(posedge clock);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clock);
      wr    <= 1'b0;
    end
  endtask
  task rd_reg(input [2:0] a, output [7:0] v);
    begin
      @(posedge clock);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock);
      rd   <= 1'b0;
      @(negedge clock);
      v = rdata;
    end
  endtask
  // polling the flags keeps the wait bounded without a fixed delay
  task wait_flag(input [7:0] m);
    integer n;
    reg [7:0] v;
    begin
      v = 8'h00;
      for (n = 0; n < 300 && (v & m) == 8'h00; n = n + 1)
        rd_reg(`MSS_OFS_FLAGS, v);
      check("flagwait", v & m, m);
    end
  endtask
  task send(input [7:0] b);
    reg [7:0] s;
    begin
      sh = 9'h000;
      wr_reg(`MSS_OFS_BUF, b);
      @(negedge clock);
      check("first", {6'h00, sda_oe, scl_oe}, {6'h00, ~b[7], 1'b1});
      rd_reg(`MSS_OFS_STATUS, s);
      check("bf", s & 8'h01, 8'h01);
      wait_flag(8'h02);
      check("wire", sh[8:1], b);
      check("nack", {7'h00, sh[0]}, 8'h01);
      wr_reg(`MSS_OFS_FLAGS, 8'h00);
    end
  endtask
  initial begin
    rows[0] = {`MSS_OFS_RELOAD, 8'h03, 8'h03};
    rows[1] = {`MSS_OFS_MASK, 8'ha5, 8'ha5};
    rows[2] = {`MSS_OFS_CON3, 8'h5a, 8'h5a};
    rows[3] = {`MSS_OFS_CON1, 8'h20, 8'h20};
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      wr_reg(rows[i][18:16], rows[i][15:8]);
      rd_reg(rows[i][18:16], d);
      check("regrw", d, rows[i][7:0]);
    end
    wr_reg(`MSS_OFS_CON2, 8'h01);
    wait_flag(8'h02);
    rd_reg(`MSS_OFS_CON2, d);
    check("sen", d & 8'h01, 8'h00);
    check("start", {6'h00, sda_oe, scl_oe}, 8'h03);
    wr_reg(`MSS_OFS_FLAGS, 8'h00);
    stretch <= 4'h3;
    send(8'h3c);
    rd_reg(`MSS_OFS_CON2, d);
    check("ackstat", d & 8'h40, 8'h40);
    stretch <= 4'h0;
    wr_reg(`MSS_OFS_CON2, 8'h02);
    wait_flag(8'h02);
    rd_reg(`MSS_OFS_CON2, d);
    check("rsen", d & 8'h02, 8'h00);
    check("rstart", {6'h00, sda_oe, scl_oe}, 8'h03);
    wr_reg(`MSS_OFS_FLAGS, 8'h00);
    // another master holds data low, so the first released bit loses
    pull_sda <= 1'b1;
    wr_reg(`MSS_OFS_BUF, 8'h80);
    wait_flag(8'h01);
    rd_reg(`MSS_OFS_STATUS, d);
    check("bf_lost", d & 8'h01, 8'h00);
    check("release", {6'h00, sda_oe, scl_oe}, 8'h00);
    wr_reg(`MSS_OFS_FLAGS, 8'h01);
    rd_reg(`MSS_OFS_FLAGS, d);
    check("sticky", d, 8'h01);
    pull_sda <= 1'b0;
    wait_flag(8'h02);
    rd_reg(`MSS_OFS_STATUS, d);
    check("stopseen", d & 8'h10, 8'h10);
    wr_reg(`MSS_OFS_FLAGS, 8'h00);
    rd_reg(`MSS_OFS_FLAGS, d);
    check("cleared", d, 8'h00);
    send(8'h55);
    sh = 9'h1ff;
    wr_reg(`MSS_OFS_CON2, 8'h10);
    wait_flag(8'h02);
    rd_reg(`MSS_OFS_CON2, d);
    check("acken", d & 8'h10, 8'h00);
    check("ackbit", {7'h00, sh[0]}, 8'h00);
    wr_reg(`MSS_OFS_FLAGS, 8'h00);
    wr_reg(`MSS_OFS_CON2, 8'h04);
    wait_flag(8'h02);
    rd_reg(`MSS_OFS_STATUS, d);
    check("stop", d & 8'h10, 8'h10);
    check("stoplines", {6'h00, sda_oe, scl_oe}, 8'h00);
    wr_reg(`MSS_OFS_FLAGS, 8'h00);
    pull_scl <= 1'b1;
    repeat (4) @(posedge clock);
    wr_reg(`MSS_OFS_CON2, 8'h01);
    wait_flag(8'h01);
    rd_reg(`MSS_OFS_CON2, d);
    check("sen_clr", d & 8'h01, 8'h00);
    check("no_drive", {6'h00, sda_oe, scl_oe}, 8'h00);
    pull_scl <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      rd_reg(i[2:0], d);
      check("rstval", d, `MSS_RST_BYTE);
    end
    stop_test;
  end
endmodule
